/* src/cqp_command_fifo_prioritizer.sv */
// six command queues, three fixed-priority arbiters, APB registers
// assumes converters take a command the cycle after ready is seen,
// and the serial link pulses tx_done once per loaded command
//
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/1ps

// Function
// - six queues, four 32-bit entries each
// - fill flag set while a slot free
// - fill request to irq or dma by select
// - partial writes still push whole word
// - circular store, push and transfer pointers
// - entries mapped at four-byte steps
// - triggered queue drives head entry out
// - empty triggered queue flags underflow, skipped
// - empty count zero, full count four
// - pop decrements count, advances transfer pointer
// - completion at converter store or serial end
// - push stores, increments count and pointer
// - push to full queue is discarded
// - lower queue number wins
// - send only if target not full, highest
// - sending stops on eoq, edge-mode pause, level-mode gate, preemption
// - three independent arbiters, same-cycle issue
// - destination from external and buffer bits
// - converter gets highest eligible or nothing
// - serial picks highest with non-full buffer
// - null message when nothing sendable
// - external fullness from returned occupancy fields
// - occupancy 11 blocks; full after reset
// - null message is programmed 26-bit pattern
module cqp_command_fifo_prioritizer
	import cqp_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [5:0]  queue_state_trig,
	input  wire logic [5:0]  gate_open,
	input  wire logic        conv0_ready,
	output logic             conv0_valid,
	output logic      [31:0] conv0_cmd,
	input  wire logic        conv1_ready,
	output logic             conv1_valid,
	output logic      [31:0] conv1_cmd,
	input  wire logic        tx_ready,
	input  wire logic        tx_done,
	output logic             tx_load,
	output logic             tx_null,
	output logic      [25:0] tx_data,
	input  wire logic        rx_valid,
	input  wire logic [3:0]  rx_busy,
	output logic      [5:0]  fill_irq,
	output logic      [5:0]  fill_dma_req,
	output logic      [5:0]  eoq_reached
);

	localparam cqp_state_type ST_RST = '{xfull: EXT_FULL_RST,
		nfmt: NULL_RST, default: '0};

	cqp_state_type          st_ff;
	cqp_state_type          nxt_st;
	logic [NQ-1:0][31:0]    head;
	logic [NQ-1:0]          act;
	logic [NQ-1:0]          hit0;
	logic [NQ-1:0]          hit1;
	logic [NQ-1:0]          hitx;
	logic [NQ-1:0]          pop;
	logic [NQ-1:0]          push;
	logic [NQ-1:0]          ufclr;
	logic                   g0;
	logic                   g1;
	logic                   gx;
	logic [2:0]             s0;
	logic [2:0]             s1;
	logic [2:0]             sx;
	logic                   setup;
	logic                   acc;
	logic                   ok;
	logic [31:0]            rv;
	logic [2:0]             qn;
	logic [2:0]             en;
	logic                   is_push;
	logic                   is_ctrl;
	logic                   is_stat;
	logic                   is_cfg;
	logic                   is_null;
	logic                   is_ent;
	logic                   pushok;

	// eligibility and fixed-priority selection per destination
	always_comb begin
		g0 = 1'b0;
		g1 = 1'b0;
		gx = 1'b0;
		s0 = 3'h0;
		s1 = 3'h0;
		sx = 3'h0;
		for (int n = 0; n < NQ; n++) begin
			head[n] = st_ff.mem[n][st_ff.tidx[n]];
			// level mode needs an open gate; stop holds after eoq, or after pause in edge mode
			act[n] = queue_state_trig[n] & ~st_ff.stop[n]
				& (~st_ff.lvl[n] | gate_open[n])
				& (st_ff.cnt[n] != 3'h0);
			hit0[n] = act[n] & ~head[n][CMD_EB] & ~head[n][CMD_BN];
			hit1[n] = act[n] & ~head[n][CMD_EB] & head[n][CMD_BN];
			hitx[n] = act[n] & head[n][CMD_EB]
				& ~st_ff.xfull[head[n][CMD_BN]];
		end
		// scan downward so the lowest number is taken last and wins
		for (int n = NQ - 1; n >= 0; n--) begin
			if (hit0[n]) begin
				g0 = 1'b1;
				s0 = 3'(n);
			end
			if (hit1[n]) begin
				g1 = 1'b1;
				s1 = 3'(n);
			end
			if (hitx[n]) begin
				gx = 1'b1;
				sx = 3'(n);
			end
		end
	end

	// APB decode, if-else chain on address windows
	always_comb begin
		qn = paddr[4:2];
		en = paddr[6:4];
		is_push = 1'b0;
		is_ctrl = 1'b0;
		is_stat = 1'b0;
		is_cfg = 1'b0;
		is_null = 1'b0;
		is_ent = 1'b0;
		ok = 1'b1;
		rv = 32'h0000_0000;
		if (paddr[1:0] != 2'h0) begin
			ok = 1'b0;
		end else if (paddr[11:5] == OFS_PUSH[11:5] && qn < 3'(NQ)) begin
			is_push = 1'b1;
		end else if (paddr[11:5] == OFS_CTRL[11:5] && qn < 3'(NQ)) begin
			is_ctrl = 1'b1;
			rv[CTRL_FRE] = st_ff.fre[qn];
			rv[CTRL_FRS] = st_ff.frs[qn];
			rv[CTRL_LVL] = st_ff.lvl[qn];
		end else if (paddr[11:5] == OFS_STAT[11:5] && qn < 3'(NQ)) begin
			is_stat = 1'b1;
			rv[STAT_FILL] = st_ff.cnt[qn] != CNT_FULL;
			rv[STAT_UF] = st_ff.uf[qn];
			rv[STAT_TIDX+:2] = st_ff.tidx[qn];
			rv[STAT_CNT+:3] = st_ff.cnt[qn];
		end else if (paddr == OFS_CFG) begin
			is_cfg = 1'b1;
			rv[CFG_SEN] = st_ff.sen;
		end else if (paddr == OFS_NULL) begin
			is_null = 1'b1;
			rv[25:0] = st_ff.nfmt;
		end else if (paddr == OFS_EXT) begin
			rv[1:0] = st_ff.xfull;
			rv[EXT_INFL] = st_ff.infl;
		end else if (paddr[11:8] == OFS_ENTRY[11:8] && paddr[7] == 1'b0
			&& en < 3'(NQ)) begin
			is_ent = 1'b1;
			rv = st_ff.mem[en][paddr[3:2]];
		end else begin
			ok = 1'b0;
		end
	end

	always_comb begin
		nxt_st = st_ff;
		nxt_st.c0v = 1'b0;
		nxt_st.c1v = 1'b0;
		nxt_st.txl = 1'b0;
		nxt_st.end_of_queue_bit = '0;
		nxt_st.rdy = 1'b0;
		nxt_st.err = 1'b0;
		pop = '0;
		push = '0;
		ufclr = '0;
		pushok = 1'b0;
		setup = psel & ~penable;
		acc = psel & penable & st_ff.rdy;

		// no wait state: answer prepared at setup, shown in the first access cycle
		if (setup) begin
			nxt_st.rdy = 1'b1;
			nxt_st.rd = rv;
			nxt_st.err = ~ok;
		end
		if (acc && pwrite && ok) begin
			// byte strobes ignored: a narrow write still pushes a word
			if (is_push) begin
				push[qn] = 1'b1;
			end else if (is_ctrl) begin
				nxt_st.fre[qn] = pwdata[CTRL_FRE];
				nxt_st.frs[qn] = pwdata[CTRL_FRS];
				nxt_st.lvl[qn] = pwdata[CTRL_LVL];
			end else if (is_stat) begin
				ufclr[qn] = pwdata[STAT_UF];
			end else if (is_cfg) begin
				nxt_st.sen = pwdata[CFG_SEN];
			end else if (is_null) begin
				nxt_st.nfmt = pwdata[25:0];
			end
		end

		// converters: stored into the buffer counts as transferred
		if (conv0_ready && g0) begin
			nxt_st.c0v = 1'b1;
			nxt_st.c0c = head[s0];
			pop[s0] = 1'b1;
		end
		if (conv1_ready && g1) begin
			nxt_st.c1v = 1'b1;
			nxt_st.c1c = head[s1];
			pop[s1] = 1'b1;
		end

		// serial: the entry stays queued until its shift-out ends
		if (st_ff.infl && tx_done) begin
			pop[st_ff.ifq] = 1'b1;
			nxt_st.infl = 1'b0;
		end
		if (st_ff.sen && tx_ready && !st_ff.infl) begin
			nxt_st.txl = 1'b1;
			if (gx) begin
				nxt_st.txn = 1'b0;
				nxt_st.txd = head[sx][25:0];
				nxt_st.infl = 1'b1;
				nxt_st.ifq = sx;
			end else begin
				nxt_st.txn = 1'b1;
				nxt_st.txd = st_ff.nfmt;
			end
		end

		if (rx_valid) begin
			nxt_st.xfull[0] = rx_busy[1:0] == BUSY_STOP;
			nxt_st.xfull[1] = rx_busy[3:2] == BUSY_STOP;
		end

		for (int n = 0; n < NQ; n++) begin
			pushok = push[n] & (st_ff.cnt[n] != CNT_FULL);
			if (pushok) begin
				nxt_st.mem[n][st_ff.pptr[n]] = pwdata;
				nxt_st.pptr[n] = st_ff.pptr[n] + 2'h1;
			end
			if (!queue_state_trig[n]) begin
				nxt_st.stop[n] = 1'b0;
			end
			if (pop[n]) begin
				nxt_st.tidx[n] = st_ff.tidx[n] + 2'h1;
				nxt_st.end_of_queue_bit[n] = head[n][CMD_EOQ];
				if (head[n][CMD_EOQ]
					|| (head[n][CMD_PAUSE] && !st_ff.lvl[n])) begin
					nxt_st.stop[n] = 1'b1;
				end
			end
			if (pushok && !pop[n]) begin
				nxt_st.cnt[n] = st_ff.cnt[n] + 3'h1;
			end else if (pop[n] && !pushok) begin
				nxt_st.cnt[n] = st_ff.cnt[n] - 3'h1;
			end
			if (ufclr[n]) begin
				nxt_st.uf[n] = 1'b0;
			end
			// set after clear so a fresh underflow is never lost
			if (queue_state_trig[n] && !st_ff.stop[n]
				&& st_ff.cnt[n] == 3'h0) begin
				nxt_st.uf[n] = 1'b1;
			end
			nxt_st.irq[n] = st_ff.fre[n] & ~st_ff.frs[n]
				& (st_ff.cnt[n] != CNT_FULL);
			nxt_st.dreq[n] = st_ff.fre[n] & st_ff.frs[n]
				& (st_ff.cnt[n] != CNT_FULL);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= ST_RST;
		end else if (ce) begin
			st_ff <= nxt_st;
		end
	end

	assign prdata       = st_ff.rd;
	assign pready       = st_ff.rdy;
	assign pslverr      = st_ff.err;
	assign conv0_valid  = st_ff.c0v;
	assign conv0_cmd    = st_ff.c0c;
	assign conv1_valid  = st_ff.c1v;
	assign conv1_cmd    = st_ff.c1c;
	assign tx_load      = st_ff.txl;
	assign tx_null      = st_ff.txn;
	assign tx_data      = st_ff.txd;
	assign fill_irq     = st_ff.irq;
	assign fill_dma_req = st_ff.dreq;
	assign eoq_reached  = st_ff.end_of_queue_bit;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_push_inc;
		ce && push[0] && st_ff.cnt[0] != CNT_FULL && !pop[0] |=>
			st_ff.cnt[0] == $past(st_ff.cnt[0]) + 3'h1
			&& st_ff.pptr[0] == $past(st_ff.pptr[0]) + 2'h1;
	endproperty
	a_push_inc: assert property (p_push_inc)
		else $error("push did not add an entry");

	property p_full_drop;
		ce && push[0] && st_ff.cnt[0] == CNT_FULL && !pop[0] |=>
			st_ff.cnt[0] == CNT_FULL && $stable(st_ff.mem[0]);
	endproperty
	a_full_drop: assert property (p_full_drop)
		else $error("push to full queue changed it");

	property p_pop;
		ce && pop[0] && !push[0] |=>
			st_ff.cnt[0] == $past(st_ff.cnt[0]) - 3'h1
			&& st_ff.tidx[0] == $past(st_ff.tidx[0]) + 2'h1;
	endproperty
	a_pop: assert property (p_pop)
		else $error("pop did not advance queue");

	property p_both;
		ce && pop[0] && push[0] && st_ff.cnt[0] != CNT_FULL |=>
			$stable(st_ff.cnt[0]);
	endproperty
	a_both: assert property (p_both)
		else $error("push with pop changed count");

	property p_fill;
		ce && st_ff.fre[0] && !st_ff.frs[0]
			&& st_ff.cnt[0] != CNT_FULL |=> fill_irq[0] && !fill_dma_req[0];
	endproperty
	a_fill: assert property (p_fill)
		else $error("fill request not raised");

	property p_conv0;
		ce && conv0_ready && hit0[0] |=>
			conv0_valid && conv0_cmd == $past(head[0]);
	endproperty
	a_conv0: assert property (p_conv0)
		else $error("top queue not sent to converter");

	property p_xfull;
		ce && rx_valid && rx_busy[3:2] == BUSY_STOP |=> st_ff.xfull[1];
	endproperty
	a_xfull: assert property (p_xfull)
		else $error("busy field did not block buffer");

	property p_null;
		ce && st_ff.sen && tx_ready && !st_ff.infl && !gx |=>
			tx_load && tx_null && tx_data == $past(st_ff.nfmt);
	endproperty
	a_null: assert property (p_null)
		else $error("null message not loaded");

	property p_uf;
		ce && queue_state_trig[0] && !st_ff.stop[0]
			&& st_ff.cnt[0] == 3'h0 |-> !pop[0] ##1 st_ff.uf[0];
	endproperty
	a_uf: assert property (p_uf)
		else $error("underflow not flagged");

	c_full: cover property (st_ff.cnt[0] == CNT_FULL);
	c_cmd: cover property (tx_load && !tx_null);
	c_all3: cover property (conv0_valid && conv1_valid && tx_load);

endmodule

/* src/cqp_pkg.sv */
// constants and state layout for the command queue prioritizer
// assumes an APB master on a 12-bit byte address, 32-bit data
package cqp_pkg;
	localparam int NQ    = 6;
	localparam int DEPTH = 4;
	localparam logic [2:0] CNT_FULL = 3'h4;

	// register byte offsets
	localparam logic [11:0] OFS_PUSH  = 12'h000;
	localparam logic [11:0] OFS_CTRL  = 12'h020;
	localparam logic [11:0] OFS_STAT  = 12'h040;
	localparam logic [11:0] OFS_CFG   = 12'h060;
	localparam logic [11:0] OFS_NULL  = 12'h064;
	localparam logic [11:0] OFS_EXT   = 12'h068;
	localparam logic [11:0] OFS_ENTRY = 12'h100;

	// request_control_register fields
	localparam int CTRL_FRE = 0;
	localparam int CTRL_FRS = 1;
	localparam int CTRL_LVL = 2;
	// fifo_status_register fields, then config and ext register bits
	localparam int STAT_FILL = 0;
	localparam int STAT_UF   = 1;
	localparam int STAT_TIDX = 4;
	localparam int STAT_CNT  = 8;
	localparam int CFG_SEN   = 0;
	localparam int EXT_INFL  = 2;

	// command word bits, lsb numbering
	localparam int CMD_EOQ   = 31;
	localparam int CMD_PAUSE = 30;
	localparam int CMD_EB    = 26;
	localparam int CMD_BN    = 25;

	localparam logic [1:0]  BUSY_STOP    = 2'h3;
	localparam logic [1:0]  EXT_FULL_RST = 2'h3;
	localparam logic [25:0] NULL_RST     = 26'h000_0000;

	typedef struct packed {
		logic [NQ-1:0][DEPTH-1:0][31:0] mem;
		logic [NQ-1:0][1:0]             pptr;
		logic [NQ-1:0][1:0]             tidx;
		logic [NQ-1:0][2:0]             cnt;
		logic [NQ-1:0]                  fre;
		logic [NQ-1:0]                  frs;
		logic [NQ-1:0]                  lvl;
		logic [NQ-1:0]                  uf;
		logic [NQ-1:0]                  stop;
		logic [NQ-1:0]                  irq;
		logic [NQ-1:0]                  dreq;
		logic [NQ-1:0]                  end_of_queue_bit;
		logic                           sen;
		logic [25:0]                    nfmt;
		logic [1:0]                     xfull;
		logic                           c0v;
		logic                           c1v;
		logic [31:0]                    c0c;
		logic [31:0]                    c1c;
		logic                           txl;
		logic                           txn;
		logic [25:0]                    txd;
		logic                           infl;
		logic [2:0]                     ifq;
		logic [31:0]                    rd;
		logic                           rdy;
		logic                           err;
	} cqp_state_type;
endpackage

/* tb/cqp_host_model.sv */
// host processor side that fills the command queues over APB
// waits for pready however long it takes; the bench timeout ends a hang
`timescale 1ns/1ps
module cqp_host_model (
	input  wire logic        pclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [11:0] paddr,
	output logic      [31:0] pwdata,
	output logic      [3:0]  pstrb,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		pstrb = 4'hf;
	end

	// request held until pready is sampled high at a rising edge
	task automatic xfer(input logic wr, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] rd, output logic er);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= 4'hf;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule

/* tb/tb_cqp_command_fifo_prioritizer.sv */
// self-checking bench for the command queue prioritizer
// assumes the host model as APB master, converters and link driven here
`timescale 1ns/1ps
module tb_cqp_command_fifo_prioritizer import cqp_pkg::*;;
	logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, conv0_cmd, conv1_cmd, rd;
	logic [3:0]  pstrb, rx_busy;
	logic [5:0]  queue_state_trig, gate_open, fill_irq, fill_dma_req;
	logic [5:0]  eoq_reached, eoq_seen;
	logic        conv0_ready, conv0_valid, conv1_ready, conv1_valid, er;
	logic        tx_ready, tx_done, tx_load, tx_null, rx_valid, nl;
	logic [25:0] tx_data, td;
	logic [31:0] c0q[$], c1q[$];
	int          n_errors, samples_checked, cyc;

	cqp_command_fifo_prioritizer DUT (.pclk(pclk), .presetn(presetn),
		.ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr),
		.queue_state_trig(queue_state_trig), .gate_open(gate_open),
		.conv0_ready(conv0_ready), .conv0_valid(conv0_valid),
		.conv0_cmd(conv0_cmd), .conv1_ready(conv1_ready),
		.conv1_valid(conv1_valid), .conv1_cmd(conv1_cmd),
		.tx_ready(tx_ready), .tx_done(tx_done), .tx_load(tx_load),
		.tx_null(tx_null), .tx_data(tx_data), .rx_valid(rx_valid),
		.rx_busy(rx_busy), .fill_irq(fill_irq),
		.fill_dma_req(fill_dma_req), .eoq_reached(eoq_reached));
	cqp_host_model HOST (.pclk(pclk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));

	always #50 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc++;
		if (conv0_valid === 1'b1)
			c0q.push_back(conv0_cmd);
		if (conv1_valid === 1'b1)
			c1q.push_back(conv1_cmd);
		eoq_seen <= eoq_seen | eoq_reached;
		if (cyc == 20000) begin
			n_errors++;
			wrap_up();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		HOST.xfer(1'b1, a, d, rd, er);
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] m,
		input logic [31:0] exp);
		HOST.xfer(1'b0, a, 32'h0000_0000, rd, er);
		chk(rd & m, exp);
	endtask
	// one transmit slot: ready for a cycle, take the load, end the shift
	task automatic ser();
		@(posedge pclk);
		tx_ready <= 1'b1;
		@(posedge pclk);
		tx_ready <= 1'b0;
		// no local limit: the cycle ceiling catches a missing load
		while (tx_load !== 1'b1) begin
			@(posedge pclk);
		end
		nl = tx_null;
		td = tx_data;
		@(posedge pclk);
		tx_done <= 1'b1;
		@(posedge pclk);
		tx_done <= 1'b0;
	endtask
	task automatic rx(input logic [3:0] b);
		@(posedge pclk);
		rx_valid <= 1'b1;
		rx_busy <= b;
		@(posedge pclk);
		rx_valid <= 1'b0;
	endtask

	task automatic t_reset_regs();
		rd_chk(OFS_STAT, 32'h0000_0733, 32'h0000_0001);
		rd_chk(OFS_EXT, 32'h0000_0003, 32'h0000_0003);
		HOST.xfer(1'b0, 12'h070, 32'h0000_0000, rd, er);
		chk({31'h0, er}, 32'h0000_0001);
	endtask
	// five pushes into queue 1, the last must be dropped
	task automatic t_fill_full();
		logic [31:0] w;
		for (int i = 0; i < 5; i++) begin
			w = 32'h0000_0A10 + 32'(i);
			w[CMD_EOQ] = (i == 3);
			wr(OFS_PUSH + 12'h004, w);
		end
		rd_chk(OFS_STAT + 12'h004, 32'h0000_0733, 32'h0000_0400);
		for (int i = 0; i < 4; i++)
			rd_chk(OFS_ENTRY + 12'h010 + 12'(4 * i), 32'hffff_ffff,
				32'h0000_0A10 + 32'(i) + ((i == 3) ? 32'h8000_0000 : 0));
	endtask
	task automatic t_fill_req();
		wr(OFS_CTRL + 12'h008, 32'h0000_0001);
		repeat (3) @(posedge pclk);
		chk({26'h0, fill_irq}, 32'h0000_0004);
		wr(OFS_CTRL + 12'h008, 32'h0000_0003);
		repeat (3) @(posedge pclk);
		chk({20'h0, fill_irq, fill_dma_req}, 32'h0000_0004);
	endtask
	// queue 0 beats queue 1 for the first converter; queue 2 to second
	task automatic t_conv();
		wr(OFS_PUSH, 32'h0000_0A00);
		wr(OFS_PUSH + 12'h008, 32'h0200_0B00);
		@(posedge pclk);
		queue_state_trig <= 6'h07;
		conv0_ready <= 1'b1;
		conv1_ready <= 1'b1;
		for (int n = 0; n < 50 && c0q.size() < 5; n++)
			@(posedge pclk);
		repeat (3) @(posedge pclk);
		chk(32'(c0q.size()), 32'h0000_0005);
		chk(32'(c1q.size()), 32'h0000_0001);
		if (c0q.size() == 5 && c1q.size() == 1) begin
			chk(c0q[0], 32'h0000_0A00);
			for (int i = 1; i < 5; i++)
				chk(c0q[i] & 32'h7fff_ffff, 32'h0000_0A0F + 32'(i));
			chk(c1q[0], 32'h0200_0B00);
		end
		rd_chk(OFS_STAT, 32'h0000_0002, 32'h0000_0002);
		rd_chk(OFS_STAT + 12'h004, 32'h0000_0731, 32'h0000_0001);
		chk({26'h0, eoq_seen}, 32'h0000_0002);
		queue_state_trig <= 6'h00;
		conv0_ready <= 1'b0;
		conv1_ready <= 1'b0;
	endtask
	// buffers start full, then buffer 0 frees up before buffer 1
	task automatic t_serial();
		wr(OFS_NULL, 32'h02AB_CDEF);
		wr(OFS_CFG, 32'h0000_0001);
		wr(OFS_PUSH + 12'h00c, 32'h0600_1234);
		wr(OFS_PUSH + 12'h010, 32'h0400_5678);
		queue_state_trig <= 6'h18;
		ser();
		chk({31'h0, nl}, 32'h0000_0001);
		chk({6'h0, td}, 32'h02AB_CDEF);
		rx(4'hc);
		ser();
		chk({31'h0, nl}, 32'h0000_0000);
		chk({6'h0, td}, 32'h0000_5678);
		rd_chk(OFS_STAT + 12'h010, 32'h0000_0700, 32'h0000_0000);
		rx(4'h0);
		ser();
		chk({6'h0, td}, 32'h0200_1234);
		queue_state_trig <= 6'h00;
	endtask
	// level mode halts on a closed gate; edge mode halts on pause
	task automatic t_gate();
		wr(OFS_CTRL + 12'h014, 32'h0000_0004);
		wr(OFS_PUSH + 12'h014, 32'h0000_0C00);
		wr(OFS_PUSH + 12'h010, 32'h4000_0D00);
		wr(OFS_PUSH + 12'h010, 32'h0000_0D01);
		gate_open <= 6'h1f;
		queue_state_trig <= 6'h30;
		conv0_ready <= 1'b1;
		repeat (10) @(posedge pclk);
		chk(32'(c0q.size()), 32'h0000_0006);
		gate_open <= 6'h3f;
		repeat (10) @(posedge pclk);
		chk(32'(c0q.size()), 32'h0000_0007);
		if (c0q.size() == 7) begin
			chk(c0q[5], 32'h4000_0D00);
			chk(c0q[6], 32'h0000_0C00);
		end
		queue_state_trig <= 6'h00;
		conv0_ready <= 1'b0;
	endtask

	task automatic wrap_up();
		$display("errors %0d, comparisons %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		ce = 1'b1;
		gate_open = 6'h3f;
		queue_state_trig = 6'h00;
		conv0_ready = 1'b0;
		conv1_ready = 1'b0;
		tx_ready = 1'b0;
		tx_done = 1'b0;
		rx_valid = 1'b0;
		rx_busy = 4'hf;
		eoq_seen = 6'h00;
		n_errors = 0;
		samples_checked = 0;
		cyc = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_reset_regs();
		t_fill_full();
		t_fill_req();
		t_conv();
		t_serial();
		t_gate();
		wrap_up();
	end
endmodule
